// ### include/pfs_pkg.sv
// package: register map, field positions and mode codes of the pin function selector
package pfs_pkg;
   // register indexes (no offsets printed, chosen locally)
   localparam logic [3:0] PORT_C_SEL_ADDR = 4'h0;
   localparam logic [3:0] PORT_E_SEL_ADDR = 4'h2;
   localparam logic [3:0] PIN_STATE_ADDR = 4'h4;
   // field positions
   localparam int PC_MODE_LSB = 4;
   localparam int PC_MODE_MSB = 11;
   localparam int PE15_LSB = 14;
   localparam int PE14_LSB = 12;
   localparam int PE13_LSB = 10;
   localparam int PE12_LSB = 8;
   // reset values
   localparam logic [15:0] PORT_C_SEL_RESET = 16'h0000;
   localparam logic [15:0] PORT_E_SEL_RESET = 16'h0000;
   // writable bits
   localparam logic [15:0] PORT_C_SEL_MASK = 16'h0FF0;
   localparam logic [15:0] PORT_E_SEL_MASK = 16'hFF00;
   // two-bit mode codes
   localparam logic [1:0] MODE_PORT = 2'h0;
   localparam logic [1:0] MODE_ALT1 = 2'h1;
   localparam logic [1:0] MODE_ALT2 = 2'h2;
   localparam logic [1:0] MODE_ALT3 = 2'h3;
endpackage

// ### rtl/pfs_pin_function_select.sv
// pin function selection for port C address pins and port E pins 15..12
// Operation
// - port C bits 11..4: 0 selects port I/O, 1 selects address output same index
// - port E bits 15:14: port, timer io d, dma ack 1, interrupt request out
// - port E bits 13:12: port, timer io c, dma ack 0; code 11 prohibited
// - port E bits 11:10: port, timer io b, manual reset input; code 11 prohibited
// - port E bits 9:8: port, timer io a, serial 3 transmit; code 10 prohibited
// - debug mode pin high forces pin 12 to test clock input
module pfs_pin_function_select (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdData,
   input wire logic debugModePin,
   // port C pins 11..4
   input wire logic [7:0] portCOut,
   input wire logic [7:0] portCOe,
   input wire logic [7:0] busAddr,
   input wire logic [7:0] portCPinIn,
   output logic [7:0] portCPinOut,
   output logic [7:0] portCPinOe,
   output logic [7:0] portCIn,
   // port E pins 15..12, index 3 = pin 15
   input wire logic [3:0] portEOut,
   input wire logic [3:0] portEOe,
   input wire logic [3:0] timerCh4Out,
   input wire logic [3:0] timerCh4Oe,
   input wire logic dmaAck1,
   input wire logic dmaAck0,
   input wire logic interruptRequestOut,
   input wire logic serial3TransmitOut,
   input wire logic [3:0] portEPinIn,
   output logic [3:0] portEPinOut,
   output logic [3:0] portEPinOe,
   output logic [3:0] portEIn,
   output logic [3:0] timerCh4In,
   output logic manualResetIn,
   output logic testClockIn
);
   typedef struct packed {
      logic [15:0] pcSel;
      logic [15:0] peSel;
      logic [15:0] rdData;
      logic [7:0] pcMeta;
      logic [7:0] pcSync;
      logic [3:0] peMeta;
      logic [3:0] peSync;
      logic dbgMeta;
      logic dbgSync;
      logic [7:0] pcPinOut;
      logic [7:0] pcPinOe;
      logic [7:0] pcIn;
      logic [3:0] pePinOut;
      logic [3:0] pePinOe;
      logic [3:0] peIn;
      logic [3:0] tmrIn;
      logic mresIn;
      logic tckIn;
   } pfs_state_s;

   pfs_state_s state;
   pfs_state_s next_state;

   // next state: register writes, synchronisers and pin routing
   always_comb begin
      logic [7:0] pcMode;
      logic [1:0] m15;
      logic [1:0] m14;
      logic [1:0] m13;
      logic [1:0] m12;
      pcMode = '0;
      m15 = '0;
      m14 = '0;
      m13 = '0;
      m12 = '0;
      next_state = state;
      // register writes, reserved bits held at zero
      if (regWrite && regAddr == pfs_pkg::PORT_C_SEL_ADDR) begin
         next_state.pcSel = regWrData & pfs_pkg::PORT_C_SEL_MASK;
      end
      if (regWrite && regAddr == pfs_pkg::PORT_E_SEL_ADDR) begin
         next_state.peSel = regWrData & pfs_pkg::PORT_E_SEL_MASK;
      end
      // read data valid one cycle after the strobe only
      next_state.rdData = 16'h0000;
      if (regRead) begin
         unique case (regAddr)
            pfs_pkg::PORT_C_SEL_ADDR: next_state.rdData = state.pcSel;
            pfs_pkg::PORT_E_SEL_ADDR: next_state.rdData = state.peSel;
            pfs_pkg::PIN_STATE_ADDR: next_state.rdData = {state.dbgSync, 3'h0, state.peSync, state.pcSync};
            default: next_state.rdData = 16'h0000;
         endcase
      end
      // two-flop synchronisers for pin inputs
      next_state.pcMeta = portCPinIn;
      next_state.pcSync = state.pcMeta;
      next_state.peMeta = portEPinIn;
      next_state.peSync = state.peMeta;
      next_state.dbgMeta = debugModePin;
      next_state.dbgSync = state.dbgMeta;
      // port C routing
      pcMode = state.pcSel[pfs_pkg::PC_MODE_MSB:pfs_pkg::PC_MODE_LSB];
      for (int i = 0; i < 8; i++) begin
         if (pcMode[i]) begin
            next_state.pcPinOut[i] = busAddr[i];
            next_state.pcPinOe[i] = 1'b1;
         end else begin
            next_state.pcPinOut[i] = portCOut[i];
            next_state.pcPinOe[i] = portCOe[i];
         end
      end
      next_state.pcIn = state.pcSync & ~pcMode;
      m15 = state.peSel[pfs_pkg::PE15_LSB +: 2];
      m14 = state.peSel[pfs_pkg::PE14_LSB +: 2];
      m13 = state.peSel[pfs_pkg::PE13_LSB +: 2];
      m12 = state.peSel[pfs_pkg::PE12_LSB +: 2];
      next_state.pePinOut = 4'h0;
      next_state.pePinOe = 4'h0;
      next_state.peIn = 4'h0;
      next_state.tmrIn = 4'h0;
      next_state.mresIn = 1'b1;
      next_state.tckIn = 1'b0;
      // pin 15
      unique case (m15)
         pfs_pkg::MODE_PORT: begin
            next_state.pePinOut[3] = portEOut[3];
            next_state.pePinOe[3] = portEOe[3];
            next_state.peIn[3] = state.peSync[3];
         end
         pfs_pkg::MODE_ALT1: begin
            next_state.pePinOut[3] = timerCh4Out[3];
            next_state.pePinOe[3] = timerCh4Oe[3];
            next_state.tmrIn[3] = state.peSync[3];
         end
         pfs_pkg::MODE_ALT2: begin
            next_state.pePinOut[3] = dmaAck1;
            next_state.pePinOe[3] = 1'b1;
         end
         pfs_pkg::MODE_ALT3: begin
            next_state.pePinOut[3] = interruptRequestOut;
            next_state.pePinOe[3] = 1'b1;
         end
      endcase
      // pin 14, code 11 leaves the pin an undriven input
      unique case (m14)
         pfs_pkg::MODE_PORT: begin
            next_state.pePinOut[2] = portEOut[2];
            next_state.pePinOe[2] = portEOe[2];
            next_state.peIn[2] = state.peSync[2];
         end
         pfs_pkg::MODE_ALT1: begin
            next_state.pePinOut[2] = timerCh4Out[2];
            next_state.pePinOe[2] = timerCh4Oe[2];
            next_state.tmrIn[2] = state.peSync[2];
         end
         pfs_pkg::MODE_ALT2: begin
            next_state.pePinOut[2] = dmaAck0;
            next_state.pePinOe[2] = 1'b1;
         end
         pfs_pkg::MODE_ALT3: next_state.pePinOe[2] = 1'b0;
      endcase
      // pin 13
      unique case (m13)
         pfs_pkg::MODE_PORT: begin
            next_state.pePinOut[1] = portEOut[1];
            next_state.pePinOe[1] = portEOe[1];
            next_state.peIn[1] = state.peSync[1];
         end
         pfs_pkg::MODE_ALT1: begin
            next_state.pePinOut[1] = timerCh4Out[1];
            next_state.pePinOe[1] = timerCh4Oe[1];
            next_state.tmrIn[1] = state.peSync[1];
         end
         pfs_pkg::MODE_ALT2: next_state.mresIn = state.peSync[1];
         pfs_pkg::MODE_ALT3: next_state.pePinOe[1] = 1'b0;
      endcase
      // pin 12, debug mode overrides the field
      if (state.dbgSync) begin
         next_state.tckIn = state.peSync[0];
      end else begin
         unique case (m12)
            pfs_pkg::MODE_PORT: begin
               next_state.pePinOut[0] = portEOut[0];
               next_state.pePinOe[0] = portEOe[0];
               next_state.peIn[0] = state.peSync[0];
            end
            pfs_pkg::MODE_ALT1: begin
               next_state.pePinOut[0] = timerCh4Out[0];
               next_state.pePinOe[0] = timerCh4Oe[0];
               next_state.tmrIn[0] = state.peSync[0];
            end
            pfs_pkg::MODE_ALT2: next_state.pePinOe[0] = 1'b0;
            pfs_pkg::MODE_ALT3: begin
               next_state.pePinOut[0] = serial3TransmitOut;
               next_state.pePinOe[0] = 1'b1;
            end
         endcase
      end
   end

   // state register with synchronous reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= '0;
         state.pcSel <= pfs_pkg::PORT_C_SEL_RESET;
         state.peSel <= pfs_pkg::PORT_E_SEL_RESET;
         state.mresIn <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // outputs straight from flip-flops
   assign regRdData = state.rdData;
   assign portCPinOut = state.pcPinOut;
   assign portCPinOe = state.pcPinOe;
   assign portCIn = state.pcIn;
   assign portEPinOut = state.pePinOut;
   assign portEPinOe = state.pePinOe;
   assign portEIn = state.peIn;
   assign timerCh4In = state.tmrIn;
   assign manualResetIn = state.mresIn;
   assign testClockIn = state.tckIn;

   // address mode drives the pin with the bus address
   a_pc_addr_out: assert property (@(posedge clk) disable iff (sys_rst)
      state.pcSel[pfs_pkg::PC_MODE_LSB] |=> (portCPinOe[0] && portCPinOut[0] == $past(busAddr[0])))
      else $error("address pin not driven");
   // port mode hands the pin to the port logic
   a_pc_port_pass: assert property (@(posedge clk) disable iff (sys_rst)
      !state.pcSel[pfs_pkg::PC_MODE_MSB] |=> (portCPinOe[7] == $past(portCOe[7])
         && portCPinOut[7] == $past(portCOut[7])))
      else $error("port pin not passed through");
   // address mode hides the pin level from the port logic
   a_pc_addr_hide: assert property (@(posedge clk) disable iff (sys_rst)
      state.pcSel[pfs_pkg::PC_MODE_MSB] |=> !portCIn[7])
      else $error("port input seen in address mode");
   // pin 15 timer d: timer enable out, pin level back to the timer
   a_pe15_timer_d: assert property (@(posedge clk) disable iff (sys_rst)
      state.peSel[pfs_pkg::PE15_LSB +: 2] == pfs_pkg::MODE_ALT1 |=> (portEPinOe[3] == $past(timerCh4Oe[3])
         && timerCh4In[3] == $past(state.peSync[3]) && !portEIn[3]))
      else $error("timer d not routed");
   // pin 15 dma ack
   a_pe15_dma_ack: assert property (@(posedge clk) disable iff (sys_rst)
      state.peSel[pfs_pkg::PE15_LSB +: 2] == pfs_pkg::MODE_ALT2 |=> (portEPinOe[3]
         && portEPinOut[3] == $past(dmaAck1)))
      else $error("dma ack 1 not routed");
   // pin 15 interrupt request
   a_pe15_irq_out: assert property (@(posedge clk) disable iff (sys_rst)
      state.peSel[pfs_pkg::PE15_LSB +: 2] == pfs_pkg::MODE_ALT3 |=> (portEPinOe[3]
         && portEPinOut[3] == $past(interruptRequestOut)))
      else $error("interrupt request not routed");
   // pin 14 dma ack
   a_pe14_dma_ack: assert property (@(posedge clk) disable iff (sys_rst)
      state.peSel[pfs_pkg::PE14_LSB +: 2] == pfs_pkg::MODE_ALT2 |=> (portEPinOe[2]
         && portEPinOut[2] == $past(dmaAck0)))
      else $error("dma ack 0 not routed");
   // pin 13 manual reset
   a_pe13_manual_reset_in_in: assert property (@(posedge clk) disable iff (sys_rst)
      state.peSel[pfs_pkg::PE13_LSB +: 2] == pfs_pkg::MODE_ALT2 |=> (!portEPinOe[1]
         && manualResetIn == $past(state.peSync[1])))
      else $error("manual reset not routed");
   // pin 12 timer a, debug mode not active
   a_pe12_timer_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state.peSel[pfs_pkg::PE12_LSB +: 2] == pfs_pkg::MODE_ALT1 && !state.dbgSync)
         |=> (portEPinOe[0] == $past(timerCh4Oe[0]) && timerCh4In[0] == $past(state.peSync[0])))
      else $error("timer a not routed");
   // pin 12 serial transmit, debug mode not active
   a_pe12_txd_out: assert property (@(posedge clk) disable iff (sys_rst)
      (state.peSel[pfs_pkg::PE12_LSB +: 2] == pfs_pkg::MODE_ALT3 && !state.dbgSync) |=> (portEPinOe[0]
         && portEPinOut[0] == $past(serial3TransmitOut)))
      else $error("serial transmit not routed");
   // debug forces test clock input
   sequence s_debug_seen;
      debugModePin ##1 debugModePin ##1 debugModePin;
   endsequence
   a_dbg_tck_force: assert property (@(posedge clk) disable iff (sys_rst)
      s_debug_seen |=> ##1 !portEPinOe[0])
      else $error("pin 12 driven in debug mode");
   // debug mode hands the pin level to the test clock only
   a_dbg_tck_level: assert property (@(posedge clk) disable iff (sys_rst)
      state.dbgSync |=> (testClockIn == $past(state.peSync[0])
         && !timerCh4In[0] && !portEIn[0]))
      else $error("test clock not routed in debug mode");
   // test clock input rests low outside debug mode
   a_tck_idle_low: assert property (@(posedge clk) disable iff (sys_rst)
      !state.dbgSync |=> !testClockIn)
      else $error("test clock active outside debug mode");
   // reset state of port E mode fields, checked on the edge after each reset edge
   a_reset_port_mode: assert property (@(posedge clk)
      sys_rst |=> (state.peSel == pfs_pkg::PORT_E_SEL_RESET && !portEPinOe[3]))
      else $error("port E fields not reset");
   // read data rest at zero outside the answer cycle
   a_rd_idle_zero: assert property (@(posedge clk) disable iff (sys_rst)
      !regRead |=> regRdData == 16'h0000)
      else $error("read data outside answer cycle");
   // pin 14 prohibited code drives nothing and feeds nothing
   a_prohibit_no_drive: assert property (@(posedge clk) disable iff (sys_rst)
      state.peSel[pfs_pkg::PE14_LSB +: 2] == pfs_pkg::MODE_ALT3 |=> (!portEPinOe[2]
         && !timerCh4In[2] && !portEIn[2]))
      else $error("prohibited code drives pin 14");
   // pin 13 prohibited code: undriven, manual reset held inactive
   a_pe13_no_drive: assert property (@(posedge clk) disable iff (sys_rst)
      state.peSel[pfs_pkg::PE13_LSB +: 2] == pfs_pkg::MODE_ALT3 |=> (!portEPinOe[1]
         && !timerCh4In[1] && !portEIn[1] && manualResetIn))
      else $error("prohibited code drives pin 13");
   // pin 12 prohibited code: undriven, nothing routed inward
   a_pe12_no_drive: assert property (@(posedge clk) disable iff (sys_rst)
      state.peSel[pfs_pkg::PE12_LSB +: 2] == pfs_pkg::MODE_ALT2 |=> (!portEPinOe[0]
         && !timerCh4In[0] && !portEIn[0]))
      else $error("prohibited code drives pin 12");
endmodule

// ### testbench/pfs_pin_model.sv
// partner model: outside world seen by the selector's pins
module pfs_pin_model #(
   parameter int W = 4
) (
   input wire logic [W-1:0] pinOut,
   input wire logic [W-1:0] pinOe,
   input wire logic [W-1:0] extLevel,
   output logic [W-1:0] pinIn
);
   timeunit 1ns;
   timeprecision 1ns;
   // driven pins read their own drive, released pins take the outside level
   assign pinIn = (pinOut & pinOe) | (extLevel & ~pinOe);
endmodule

// ### testbench/testbench.sv
// self-checking bench of the pin function selector
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
   $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, sys_rst = 1, regWrite = 0, regRead = 0, debugModePin = 0;
   logic [3:0] regAddr = '0, extE = '0, peIn, peOut, peOe, tIn, eIn;
   logic [15:0] regWrData = '0, rdData;
   logic [7:0] pcIn, pcOut, pcOe, pcSync;
   // peripheral and port logic levels seen by the selector
   logic [7:0] pcPortOut = 8'h3C, pcPortOe = 8'h0F, addrBus = 8'hA5;
   logic [3:0] eOut = 4'h5, eOe = 4'hB, tOut = 4'hA, tOe = 4'h7;
   logic ack1 = 1'b1, ack0 = 1'b0, irq = 1'b1, txd = 1'b1;
   logic manual_reset_in, tck;
   int num_errors = 0, comparisons = 0;
   // 20 MHz clock
   always #25 clk = ~clk;
   pfs_pin_model #(.W(8)) i_pc (.pinOut(pcOut), .pinOe(pcOe), .extLevel(8'h00), .pinIn(pcIn));
   pfs_pin_model #(.W(4)) i_pe (.pinOut(peOut), .pinOe(peOe), .extLevel(extE), .pinIn(peIn));
   pfs_pin_function_select i_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(rdData), .debugModePin(debugModePin),
      .portCOut(pcPortOut), .portCOe(pcPortOe), .busAddr(addrBus), .portCPinIn(pcIn), .portCPinOut(pcOut),
      .portCPinOe(pcOe), .portCIn(pcSync), .portEOut(eOut), .portEOe(eOe), .timerCh4Out(tOut),
      .timerCh4Oe(tOe), .dmaAck1(ack1), .dmaAck0(ack0), .interruptRequestOut(irq),
      .serial3TransmitOut(txd), .portEPinIn(peIn), .portEPinOut(peOut), .portEPinOe(peOe),
      .portEIn(eIn), .timerCh4In(tIn), .manualResetIn(manual_reset_in), .testClockIn(tck));
   // one-cycle register write
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   // one-cycle read, data taken in the following cycle
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      `CHK(rdData, exp)
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // registers and pins after reset, unmapped index
   task automatic check_reset;
      rd(pfs_pkg::PORT_C_SEL_ADDR, 16'h0000);
      rd(pfs_pkg::PORT_E_SEL_ADDR, 16'h0000);
      rd(4'hF, 16'h0000);
      `CHK(peOe, 4'hB)
   endtask
   // port C address or port function per bit
   task automatic check_port_c;
      wr(pfs_pkg::PORT_C_SEL_ADDR, 16'hFFFF);
      rd(pfs_pkg::PORT_C_SEL_ADDR, 16'h0FF0);
      settle(2);
      `CHK(pcOut & pcOe, 8'hA5)
      wr(pfs_pkg::PORT_C_SEL_ADDR, 16'h0AA0);
      settle(4);
      `CHK(pcOe, 8'hAF)
      `CHK(pcOut & 8'hAF, 8'hA4)
      `CHK(pcSync, 8'h04)
   endtask
   // every code of every port E field, prohibited ones included
   task automatic check_port_e;
      logic [3:0] eo, ev, ei, ti;
      for (int c = 0; c < 4; c++) begin
         wr(pfs_pkg::PORT_E_SEL_ADDR, 16'(c) * 16'h5500);
         settle(4);
         case (c)
            0: begin eo = 4'hB; ev = 4'h1; ei = 4'h1; ti = 4'h0; end
            1: begin eo = 4'h7; ev = 4'h2; ei = 4'h0; ti = 4'h2; end
            2: begin eo = 4'hC; ev = 4'h8; ei = 4'h0; ti = 4'h0; end
            default: begin eo = 4'h9; ev = 4'h9; ei = 4'h0; ti = 4'h0; end
         endcase
         `CHK(peOe, eo)
         `CHK(peOut & eo, ev)
         `CHK(eIn, ei)
         `CHK(tIn, ti)
         `CHK(manual_reset_in, 1'(c != 2))
      end
      `CHK(tIn, 4'h0)
   endtask
   // debug pin takes pin 12 over as test clock input
   task automatic check_debug;
      wr(pfs_pkg::PORT_E_SEL_ADDR, 16'h0300);
      extE <= 4'h1;
      debugModePin <= 1'b1;
      settle(5);
      `CHK(peOe[0], 1'b0)
      `CHK(tck, 1'b1)
      rd(pfs_pkg::PIN_STATE_ADDR, 16'h81A4);
      extE <= 4'h0;
      settle(5);
      `CHK(tck, 1'b0)
      debugModePin <= 1'b0;
      settle(5);
      `CHK(peOe[0], 1'b1)
   endtask
   // reset in mid-run clears both selects and returns pins to port I/O
   task automatic check_mid_reset;
      wr(pfs_pkg::PORT_E_SEL_ADDR, 16'hAA00);
      wr(pfs_pkg::PORT_C_SEL_ADDR, 16'h0FF0);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(pfs_pkg::PORT_E_SEL_ADDR, 16'h0000);
      rd(pfs_pkg::PORT_C_SEL_ADDR, 16'h0000);
      `CHK(peOe, 4'hB)
      `CHK(manual_reset_in, 1'b1)
   endtask
   task automatic results;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      results();
   end
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      check_reset();
      check_port_c();
      check_port_e();
      check_debug();
      check_mid_reset();
      results();
   end
endmodule
